// ==== common/drive_monitor_defines.vh ====
`ifndef DRIVE_MONITOR_DEFINES_VH
`define DRIVE_MONITOR_DEFINES_VH

// silent bit periods before a fault is declared
`define SILENCE_LIMIT 128
// width of the per-channel silence counter
`define SILENCE_COUNT_WIDTH 8
// counter value after reset or after a pulse
`define SILENCE_COUNT_RESET 8'h00
// fault output value after reset
`define FAULT_RESET 1'b0
// number of channels
`define CHANNEL_COUNT 12

`endif

// ==== hw/channel_silence_monitor.v ====
`timescale 1ns/10ps
`include "drive_monitor_defines.vh"
`default_nettype none

module channel_silence_monitor #(
   parameter LIMIT = `SILENCE_LIMIT,
   parameter CW = `SILENCE_COUNT_WIDTH
) (
   input wire clk,
   input wire sys_rst,
   input wire bit_tick,
   input wire pulse_seen,
   output reg fault
);
   reg [CW-1:0] silent_count;
   localparam [31:0] LAST_FULL = LIMIT - 1;
   // the limit must fit the counter width; upper bits are cut on purpose
   localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];

   always @(posedge clk) begin
      if (sys_rst) begin
         silent_count <= `SILENCE_COUNT_RESET;
         fault <= `FAULT_RESET;
      end else if (pulse_seen) begin
         silent_count <= `SILENCE_COUNT_RESET;
         fault <= 1'b0;
      end else if (bit_tick) begin
         // saturate so the fault holds through long silence
         if (silent_count == LAST) begin
            fault <= 1'b1;
         end else begin
            silent_count <= silent_count + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // channel_silence_monitor

`default_nettype wire

// ==== hw/transmit_drive_monitor.v ====
`timescale 1ns/10ps
`include "drive_monitor_defines.vh"
`default_nettype none

module transmit_drive_monitor #(
   parameter CHANNELS = `CHANNEL_COUNT,
   parameter LIMIT = `SILENCE_LIMIT
) (
   input wire clk,
   input wire sys_rst,
   input wire [CHANNELS-1:0] tx_bit_clk,
   input wire [CHANNELS-1:0] monitor_pos_in,
   input wire [CHANNELS-1:0] monitor_neg_in,
   input wire [CHANNELS-1:0] line_out_pos,
   input wire [CHANNELS-1:0] line_out_neg,
   input wire [CHANNELS-1:0] internal_select,
   output wire [CHANNELS-1:0] drive_fault_out
);
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_channel
         reg [1:0] clk_sync;
         reg [1:0] sel_sync;
         reg [1:0] ext_pos_sync;
         reg [1:0] ext_neg_sync;
         reg [1:0] int_pos_sync;
         reg [1:0] int_neg_sync;
         reg clk_prev;
         reg pos_prev;
         reg neg_prev;
         reg src_pos;
         reg src_neg;
         reg pos_rise;
         reg neg_rise;
         reg tick;
         reg pulse;

         // bit clock is a pin; two flops before the edge detector
         always @(posedge clk) begin
            if (sys_rst) begin
               clk_sync <= 2'h0;
            end else begin
               clk_sync <= {clk_sync[0], tx_bit_clk[ch]};
            end
         end

         // select synced with the same delay as the rails, so they line up
         always @(posedge clk) begin
            if (sys_rst) begin
               sel_sync <= 2'h0;
            end else begin
               sel_sync <= {sel_sync[0], internal_select[ch]};
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               ext_pos_sync <= 2'h0;
            end else begin
               ext_pos_sync <= {ext_pos_sync[0], monitor_pos_in[ch]};
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               ext_neg_sync <= 2'h0;
            end else begin
               ext_neg_sync <= {ext_neg_sync[0], monitor_neg_in[ch]};
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               int_pos_sync <= 2'h0;
            end else begin
               int_pos_sync <= {int_pos_sync[0], line_out_pos[ch]};
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               int_neg_sync <= 2'h0;
            end else begin
               int_neg_sync <= {int_neg_sync[0], line_out_neg[ch]};
            end
         end

         // unselected rails never reach the detector
         always @* begin
            src_pos = ext_pos_sync[1];
            src_neg = ext_neg_sync[1];
            if (sel_sync[1]) begin
               src_pos = int_pos_sync[1];
               src_neg = int_neg_sync[1];
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               clk_prev <= 1'b0;
            end else begin
               clk_prev <= clk_sync[1];
            end
         end

         // rails idle low, so a low history gives no false pulse after reset
         always @(posedge clk) begin
            if (sys_rst) begin
               pos_prev <= 1'b0;
            end else begin
               pos_prev <= src_pos;
            end
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               neg_prev <= 1'b0;
            end else begin
               neg_prev <= src_neg;
            end
         end

         always @* begin
            tick = clk_sync[1] & ~clk_prev;
         end

         // rising edge of either rail is one pulse; a held rail counts once
         always @* begin
            pos_rise = src_pos & ~pos_prev;
            neg_rise = src_neg & ~neg_prev;
            pulse = pos_rise | neg_rise;
         end

         channel_silence_monitor #(
            .LIMIT(LIMIT),
            .CW(`SILENCE_COUNT_WIDTH)
         ) u_mon (
            .clk(clk),
            .sys_rst(sys_rst),
            .bit_tick(tick),
            .pulse_seen(pulse),
            .fault(drive_fault_out[ch])
         );
      end
   endgenerate
endmodule // transmit_drive_monitor

`default_nettype wire

// ==== test/drive_monitor_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module drive_monitor_asserts #(parameter CHANNELS = 12, LIMIT = 128) (
   input wire logic clk, sys_rst,
   input wire logic [CHANNELS-1:0] line_out_pos, line_out_neg, internal_select, drive_fault_out);
   wire f = drive_fault_out[0];
   wire [1:0] s = {line_out_pos[0], line_out_neg[0]};
   logic [1:0] sp = 0;
   logic [15:0] q = 0;
   wire e = |(s & ~sp);
   // cycles since the last internal rail edge on channel 0
   always @(posedge clk) begin
      sp <= s;
      q <= e ? 16'h0 : q + 16'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_rst_low: assert property ($fell(sys_rst) |-> !f) else $error("no reset");
   a_edge_clears: assert property (internal_select[0] && e |-> ##[1:4] !f) else $error("stuck");
   a_fall_cause: assert property ($fell(f) && internal_select[0] |-> q < 6) else $error("fell");
   a_rise_quiet: assert property ($rose(f) |-> q > 4 * LIMIT - 4) else $error("early");
   a_fault_holds: assert property (f && q > 5 |=> f) else $error("dropped");
   a_neg_rail: assert property (internal_select[0] && $rose(s[0]) |-> ##[1:4] !f) else $error("neg");
   a_chan_apart: assert property (internal_select[1] && $rose(line_out_pos[1]) |-> ##[1:4] !drive_fault_out[1])
      else $error("ch1");
   cover property ($rose(f));
   cover property ($fell(f));
   cover property ($rose(drive_fault_out[1]));
endmodule // drive_monitor_asserts
`default_nettype wire

// ==== test/line_driver_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module line_driver_model (input wire logic clk, input wire logic [1:0] on, output logic [1:0] bclk, pos, neg);
   logic [3:0] c = 0;
   always @(posedge clk) c <= c + 4'h1;
   // bit period of 8 clk; alternating polarity, return to zero between pulses
   assign bclk = {2{c[2]}};
   assign pos = on & {2{c[2] & c[3]}};
   assign neg = on & {2{c[2] & !c[3]}};
endmodule // line_driver_model
`default_nettype wire

// ==== test/transmit_drive_monitor_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module transmit_drive_monitor_test;
   logic clk = 0, sys_rst = 1, w = 1;
   logic [1:0] on = 0, sel = 0, nz = 0, bclk, pos, neg, f, e;
   int miscompares = 0, checks = 0, sil[2] = '{0, 0};
   always #2 clk = !clk;
   line_driver_model drv(.clk(clk), .on(on), .bclk(bclk), .pos(pos), .neg(neg));
   transmit_drive_monitor #(.CHANNELS(2), .LIMIT(4)) dut(.clk(clk), .sys_rst(sys_rst), .tx_bit_clk(bclk),
      .monitor_pos_in(w ? pos : nz), .monitor_neg_in(w ? neg : ~nz), .line_out_pos(pos),
      .line_out_neg(neg), .internal_select(sel), .drive_fault_out(f));
   task close_out;
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task cmp(logic [1:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h %h", $time, seen, exp);
      end
   endtask
   // unwired monitors carry noise; silence counted in bit periods
   task run(logic [1:0] o, s, logic wb, int n);
      {on, sel, w} = {o, s, wb};
      repeat (n * 8) begin
         @(negedge clk);
         nz = 2'($urandom);
      end
      for (int i = 0; i < 2; i++) begin
         sil[i] = o[i] ? 0 : sil[i] + n;
         e[i] = sil[i] > 4;
      end
      cmp(f, e);
   endtask
   initial begin
      void'($urandom(32'hF8B2));
      repeat (4) @(negedge clk);
      sys_rst = 0;
      run(2'h3, 2'h3, 1, 3);
      run(2'h1, 2'h3, 1, 7);
      run(2'h3, 2'h3, 1, 2);
      run(2'h0, 2'h0, 1, 2);
      run(2'h0, 2'h0, 1, 5);
      run(2'h3, 2'h0, 1, 2);
      run(2'h0, 2'h3, 0, 7);
      close_out;
   end
endmodule // transmit_drive_monitor_test
bind transmit_drive_monitor drive_monitor_asserts #(.CHANNELS(CHANNELS), .LIMIT(LIMIT)) chk(.clk(clk),
   .sys_rst(sys_rst), .line_out_pos(line_out_pos), .line_out_neg(line_out_neg),
   .internal_select(internal_select), .drive_fault_out(drive_fault_out));
`default_nettype wire
